// >>> dwsr_defines.svh
// constants of the dual wiper spi register slave
`ifndef DWSR_DEFINES_SVH
`define DWSR_DEFINES_SVH

`define DWSR_ADDR_CH0 5'h00
`define DWSR_ADDR_CH1 5'h01
`define DWSR_ADDR_ACR 5'h10

`define DWSR_WIPER_RST 8'h80
`define DWSR_ACR_RST 8'h40
`define DWSR_ACR_MASK 8'h42
`define DWSR_ACR_POWER_DOWN_N_BIT 6
`define DWSR_ACR_OD_BIT 1

`define DWSR_OP_NOP 3'h0
`define DWSR_OP_ACR_RD 3'h1
`define DWSR_OP_ACR_WR 3'h3
`define DWSR_OP_REG_RD 3'h4
`define DWSR_OP_REG_WR 3'h6
`define DWSR_OP_ECHO 3'h7

`define DWSR_FRAME_BITS 5'h10
`define DWSR_LAST_BIT 4'hf
`define DWSR_TAP_LOW 8'h00

`endif

// >>> dwsr_pkg.sv
// types of the dual wiper spi register slave
package dwsr_pkg;
  typedef enum logic [1:0] {
    LNK_WAIT_FIRST,
    LNK_IDLE,
    LNK_ACTIVE
  } dwsr_link_t;
endpackage

// >>> dwsr_pin_if.sv
// synchronised spi pin events passed from the pin stage to the core
`timescale 1ns/100ps
`default_nettype none
interface dwsr_pin_if;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic cs_n;
  logic sdi;
  modport src (output sck_rise, output sck_fall, output cs_fall, output cs_rise,
               output cs_n, output sdi);
  modport dst (input sck_rise, input sck_fall, input cs_fall, input cs_rise,
               input cs_n, input sdi);
endinterface
`default_nettype wire

// >>> dwsr_pin_sync.sv
// three-flop pin synchronisers and edge finders for sck, chip select and sdi
`timescale 1ns/100ps
`default_nettype none
module dwsr_pin_sync (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  dwsr_pin_if.src pin
);
  logic [2:0] s1_ff;
  logic [2:0] s2_ff;
  logic [2:0] s3_ff;
  logic [2:0] lvl_ff;
  logic [2:0] nxt_lvl;
  logic [2:0] rise_ff;
  logic [2:0] fall_ff;

  // a change counts only once the second and third stages agree
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      nxt_lvl[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : lvl_ff[i];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s1_ff <= 3'h2;
      s2_ff <= 3'h2;
      s3_ff <= 3'h2;
      lvl_ff <= 3'h2;
      rise_ff <= 3'h0;
      fall_ff <= 3'h0;
    end else if (clk_en) begin
      s1_ff <= {spi_sdi, spi_cs_n, spi_sck};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lvl_ff <= nxt_lvl;
      rise_ff <= nxt_lvl & ~lvl_ff;
      fall_ff <= ~nxt_lvl & lvl_ff;
    end
  end

  assign pin.sck_rise = rise_ff[0] & clk_en;
  assign pin.sck_fall = fall_ff[0] & clk_en;
  assign pin.cs_rise = rise_ff[1] & clk_en;
  assign pin.cs_fall = fall_ff[1] & clk_en;
  assign pin.cs_n = lvl_ff[1];
  assign pin.sdi = lvl_ff[2];
endmodule
`default_nettype wire

// >>> dwsr_top.sv
// spi mode 0 register slave of a dual 256-position potentiometer
`timescale 1ns/100ps
`default_nettype none
`include "dwsr_defines.svh"
module dwsr_top
  import dwsr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo_o,
  output logic spi_sdo_oe,
  output logic [7:0] wiper_tap_ch0,
  output logic [7:0] wiper_tap_ch1,
  output logic power_down_n,
  output logic standby
);

  dwsr_pin_if pin ();

  dwsr_pin_sync u_pin_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .clk_en(clk_en),
    .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n),
    .spi_sdi(spi_sdi),
    .pin(pin)
  );

  dwsr_link_t link_ff;
  logic [15:0] in_sr_ff;
  logic [15:0] nxt_in_sr;
  logic [3:0] bit_cnt_ff;
  logic full_ff;
  logic [7:0] wiper_position_ch0_ff;
  logic [7:0] wiper_position_ch1_ff;
  logic [7:0] access_control_ff;
  logic [15:0] resp_sr_ff;
  logic [4:0] resp_cnt_ff;
  logic pend_ff;
  logic [7:0] pend_instr_ff;
  logic sdo_ff;
  logic [7:0] tap0_ff;
  logic [7:0] tap1_ff;
  logic active;
  logic pair_done;
  logic aligned_end;
  logic [15:0] pair_word;
  logic [15:0] pend_word;

  // register a read or write instruction addresses; control opcodes ignore the field
  function automatic logic [4:0] target_addr(input logic [7:0] instr);
    logic [2:0] op;
    op = instr[7:5];
    if (op == `DWSR_OP_ACR_RD || op == `DWSR_OP_ACR_WR) begin
      target_addr = `DWSR_ADDR_ACR;
    end else begin
      target_addr = instr[4:0];
    end
  endfunction

  function automatic logic is_read(input logic [7:0] instr);
    is_read = (instr[7:5] == `DWSR_OP_ACR_RD) || (instr[7:5] == `DWSR_OP_REG_RD);
  endfunction

  function automatic logic is_write(input logic [7:0] instr);
    is_write = (instr[7:5] == `DWSR_OP_ACR_WR) || (instr[7:5] == `DWSR_OP_REG_WR);
  endfunction

  // echo byte then register contents; unmapped addresses read as zero
  function automatic logic [15:0] read_word(input logic [7:0] instr,
                                            input logic [7:0] w0,
                                            input logic [7:0] w1,
                                            input logic [7:0] access_control);
    logic [4:0] a;
    logic [7:0] d;
    a = target_addr(instr);
    case (a)
      `DWSR_ADDR_CH0: d = w0;
      `DWSR_ADDR_CH1: d = w1;
      `DWSR_ADDR_ACR: d = access_control;
      default: d = 8'h00;
    endcase
    read_word = {`DWSR_OP_ECHO, a, d};
  endfunction

  assign active = (link_ff == LNK_ACTIVE) && !pin.cs_n;
  assign nxt_in_sr = {in_sr_ff[14:0], pin.sdi};
  assign pair_done = active && pin.sck_rise && (bit_cnt_ff == `DWSR_LAST_BIT);
  assign aligned_end = pin.cs_rise && (link_ff == LNK_ACTIVE) && full_ff &&
                       (bit_cnt_ff == 4'h0);
  assign pair_word = read_word(nxt_in_sr[15:8], wiper_position_ch0_ff,
                               wiper_position_ch1_ff, access_control_ff);
  assign pend_word = read_word(pend_instr_ff, wiper_position_ch0_ff,
                               wiper_position_ch1_ff, access_control_ff);

  // nothing happens until the first chip select fall after reset
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      link_ff <= LNK_WAIT_FIRST;
    end else if (clk_en) begin
      case (link_ff)
        LNK_WAIT_FIRST: begin
          if (pin.cs_fall) begin
            link_ff <= LNK_ACTIVE;
          end
        end
        LNK_IDLE: begin
          if (pin.cs_fall) begin
            link_ff <= LNK_ACTIVE;
          end
        end
        LNK_ACTIVE: begin
          if (pin.cs_rise) begin
            link_ff <= LNK_IDLE;
          end
        end
        default: link_ff <= LNK_WAIT_FIRST;
      endcase
    end
  end

  // input shifter; its last sixteen bits are the instruction and data pair
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      in_sr_ff <= 16'h0000;
      bit_cnt_ff <= 4'h0;
      full_ff <= 1'b0;
    end else if (clk_en) begin
      if (pin.cs_fall) begin
        in_sr_ff <= 16'h0000;
        bit_cnt_ff <= 4'h0;
        full_ff <= 1'b0;
      end else if (active && pin.sck_rise) begin
        in_sr_ff <= nxt_in_sr;
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
        if (bit_cnt_ff == `DWSR_LAST_BIT) begin
          full_ff <= 1'b1;
        end
      end
    end
  end

  // writes land only on chip select rise, so a chain updates as one
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wiper_position_ch0_ff <= `DWSR_WIPER_RST;
      wiper_position_ch1_ff <= `DWSR_WIPER_RST;
      access_control_ff <= `DWSR_ACR_RST;
    end else if (clk_en && aligned_end && is_write(in_sr_ff[15:8])) begin
      case (target_addr(in_sr_ff[15:8]))
        `DWSR_ADDR_CH0: wiper_position_ch0_ff <= in_sr_ff[7:0];
        `DWSR_ADDR_CH1: wiper_position_ch1_ff <= in_sr_ff[7:0];
        `DWSR_ADDR_ACR: access_control_ff <= in_sr_ff[7:0] & `DWSR_ACR_MASK;
        default: wiper_position_ch0_ff <= wiper_position_ch0_ff;
      endcase
    end
  end

  // sdo: read answer when one is loaded, else sdi delayed by sixteen clocks
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      resp_sr_ff <= 16'h0000;
      resp_cnt_ff <= 5'h00;
      pend_ff <= 1'b0;
      pend_instr_ff <= 8'h00;
      sdo_ff <= 1'b0;
    end else if (clk_en) begin
      if (pin.cs_fall) begin
        resp_cnt_ff <= 5'h00;
        sdo_ff <= 1'b0;
        if (pend_ff) begin
          // chained read: answer starts before the first rising edge
          sdo_ff <= pend_word[15];
          resp_sr_ff <= {pend_word[14:0], 1'b0};
          resp_cnt_ff <= `DWSR_FRAME_BITS - 5'h01;
          pend_ff <= 1'b0;
        end
      end else if (pair_done && is_read(nxt_in_sr[15:8])) begin
        resp_sr_ff <= pair_word;
        resp_cnt_ff <= `DWSR_FRAME_BITS;
      end else if (active && pin.sck_fall) begin
        if (resp_cnt_ff != 5'h00) begin
          sdo_ff <= resp_sr_ff[15];
          resp_sr_ff <= {resp_sr_ff[14:0], 1'b0};
          resp_cnt_ff <= resp_cnt_ff - 5'h01;
        end else begin
          sdo_ff <= in_sr_ff[15];
        end
      end
      if (pin.cs_rise) begin
        resp_cnt_ff <= 5'h00;
        // a read left in the window is answered in the next frame
        pend_ff <= aligned_end && is_read(in_sr_ff[15:8]);
        pend_instr_ff <= in_sr_ff[15:8];
      end
    end
  end

  // shutdown forces the tap low but leaves the stored codes alone
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tap0_ff <= `DWSR_WIPER_RST;
      tap1_ff <= `DWSR_WIPER_RST;
    end else if (clk_en) begin
      if (!access_control_ff[`DWSR_ACR_POWER_DOWN_N_BIT]) begin
        tap0_ff <= `DWSR_TAP_LOW;
        tap1_ff <= `DWSR_TAP_LOW;
      end else begin
        tap0_ff <= wiper_position_ch0_ff;
        tap1_ff <= wiper_position_ch1_ff;
      end
    end
  end

  assign wiper_tap_ch0 = tap0_ff;
  assign wiper_tap_ch1 = tap1_ff;
  assign power_down_n = access_control_ff[`DWSR_ACR_POWER_DOWN_N_BIT];
  assign standby = !active;
  // open drain only ever pulls low; the pull-up lives off chip
  assign spi_sdo_o = sdo_ff & !access_control_ff[`DWSR_ACR_OD_BIT];
  assign spi_sdo_oe = active && (!access_control_ff[`DWSR_ACR_OD_BIT] || !sdo_ff);

endmodule
`default_nettype wire

// >>> dwsr_top_properties.sv
// port-level checks of the potentiometer spi slave
`timescale 1ns/100ps
`default_nettype none
module dwsr_top_properties (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_sdo_o,
  input wire logic spi_sdo_oe,
  input wire logic [7:0] wiper_tap_ch0,
  input wire logic [7:0] wiper_tap_ch1,
  input wire logic power_down_n,
  input wire logic standby
);
  default clocking cb @(posedge sys_clk); endclocking
  // a frozen clock enable stalls every reaction, so checks rest with it
  default disable iff (srst || !clk_en);
  a_reset_values: assert property ($fell(srst) |-> wiper_tap_ch0 == 8'h80
    && wiper_tap_ch1 == 8'h80 && power_down_n && standby && !spi_sdo_oe) else $error("bad reset");
  a_idle_release: assert property (spi_cs_n [*6] |-> !spi_sdo_oe) else $error("sdo driven");
  a_idle_standby: assert property (spi_cs_n [*6] |-> standby) else $error("no standby");
  a_active_mode: assert property (!spi_cs_n [*6] |-> !standby) else $error("not active");
  a_oe_active: assert property (spi_sdo_oe |-> !standby
    && !$past(spi_cs_n, 4)) else $error("oe while deselected");
  // sync latency puts the sdo update a few clocks into the low phase
  a_sdo_on_fall: assert property ($changed(spi_sdo_o) |-> !$past(spi_sck, 2)
    && !$past(spi_sck, 4)) else $error("sdo moved off fall");
  a_hold_in_frame: assert property (!spi_cs_n [*8] |-> $stable(wiper_tap_ch0)
    && $stable(wiper_tap_ch1) && $stable(power_down_n)) else $error("early update");
  a_shut_taps: assert property (!power_down_n [*3] |-> wiper_tap_ch0 == 8'h00
    && wiper_tap_ch1 == 8'h00) else $error("tap live in shutdown");
endmodule
`default_nettype wire

// >>> dwsr_spi_host.sv
// spi mode 0 host model driving the slave pins
`timescale 1ns/100ps
`default_nettype none
module dwsr_spi_host (
  input wire logic sys_clk,
  input wire logic sdo_line,
  output logic sck,
  output logic cs_n,
  output logic sdi
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // 16 cycles a half period: 160 ns link clock, idle low between frames
  task automatic hp();
    repeat (16) @(negedge sys_clk);
  endtask
  // cs falls first and stays low over all bits, msb first
  task automatic frame(input logic [31:0] tx, input int nb, output logic [31:0] rx);
    rx = '0;
    cs_n = 1'b0;
    hp();
    for (int i = nb - 1; i >= 0; i--) begin
      sdi = tx[i];
      hp();
      sck = 1'b1;
      rx = {rx[30:0], sdo_line};
      hp();
      sck = 1'b0;
    end
    cs_n = 1'b1;
    sdi = ~sdi; // released line must not look stable
    repeat (80) @(negedge sys_clk);
  endtask
endmodule
`default_nettype wire

// >>> dwsr_top_tb_top.sv
// self-checking bench of the potentiometer spi slave
`timescale 1ns/100ps
`default_nettype none
module dwsr_top_tb_top;
  logic sys_clk = 1'b0;
  logic srst, clk_en, spi_sck, spi_cs_n, spi_sdi, spi_sdo_o, spi_sdo_oe, power_down_n, standby;
  logic [7:0] wiper_tap_ch0, wiper_tap_ch1, w0, w1, access_control;
  logic [7:0] ops [6] = '{8'hc0, 8'hc1, 8'h70, 8'hc2, 8'h50, 8'ha0};
  logic [7:0] rds [6] = '{8'h80, 8'h81, 8'h30, 8'h90, 8'h82, 8'h27};
  logic [31:0] rx;
  logic tgl = 1'b0;
  int err_count, n_checks;
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) tgl <= ~tgl;
  // open drain needs the pull-up, a floating push-pull line wanders
  wire logic line = spi_sdo_oe ? spi_sdo_o : (access_control[1] ? 1'b1 : tgl);
  dwsr_top dwsr_top_inst (.sys_clk, .srst, .clk_en, .spi_sck, .spi_cs_n, .spi_sdi, .spi_sdo_o,
    .spi_sdo_oe, .wiper_tap_ch0, .wiper_tap_ch1, .power_down_n, .standby);
  dwsr_spi_host dwsr_spi_host_inst (.sys_clk, .sdo_line(line), .sck(spi_sck), .cs_n(spi_cs_n),
    .sdi(spi_sdi));
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic taps();
    chk("tap0", access_control[6] ? w0 : 8'h00, wiper_tap_ch0);
    chk("tap1", access_control[6] ? w1 : 8'h00, wiper_tap_ch1);
    chk("pdn", access_control[6], power_down_n);
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    dwsr_spi_host_inst.frame({16'h0000, i, d}, 16, rx);
    chk("echo", 16'h0000, rx[15:0]);
    if (i[7:5] == 3'h3 || i == 8'hd0) access_control = d & 8'h42;
    else if (i == 8'hc0) w0 = d;
    else if (i == 8'hc1) w1 = d;
    taps();
  endtask
  task automatic rd(input logic [7:0] i);
    logic [4:0] a;
    logic [7:0] e;
    // control read opcode ignores its address field
    a = i[7:5] == 3'h1 ? 5'h10 : i[4:0];
    e = a == 5'h00 ? w0 : a == 5'h01 ? w1 : a == 5'h10 ? access_control : 8'h00;
    dwsr_spi_host_inst.frame({i, 8'($urandom), 8'h00, 8'($urandom)}, 32, rx);
    chk("lead", 16'h0000, rx[31:16]);
    chk("rdata", {3'h7, a, e}, rx[15:0]);
  endtask
  initial begin
    srst = 1'b1;
    clk_en = 1'b1;
    err_count = 0;
    n_checks = 0;
    w0 = 8'h80;
    w1 = 8'h80;
    access_control = 8'h40;
    void'($urandom(44095));
    repeat (12) @(negedge sys_clk);
    srst = 1'b0;
    taps();
    rd(8'h90);
    for (int k = 0; k < 12; k++) begin
      wr(ops[k % 6], 8'($urandom));
      rd(rds[k % 6]);
    end
    wr(8'hd0, 8'h42);
    rd(8'h81);
    wr(8'hd0, 8'h00);
    wr(8'hc0, 8'h3c);
    wr(8'hd0, 8'h40);
    // only the last pair counts when several are shifted through
    dwsr_spi_host_inst.frame({8'hc0, 8'h11, 8'hc1, 8'h22}, 32, rx);
    w1 = 8'h22;
    chk("chain", 16'hc011, rx[15:0]);
    taps();
    // read parked at chip select rise, answered in the next frame
    dwsr_spi_host_inst.frame({16'h0000, 8'h81, 8'($urandom)}, 16, rx);
    chk("park", 16'h0000, rx[15:0]);
    dwsr_spi_host_inst.frame(32'h00000000, 16, rx);
    chk("chain_rd", {3'h7, 5'h01, w1}, rx[15:0]);
    // frozen clock enable: a whole write frame must go unseen
    clk_en = 1'b0;
    dwsr_spi_host_inst.frame({16'h0000, 8'hc0, 8'($urandom)}, 16, rx);
    clk_en = 1'b1;
    taps();
    dwsr_spi_host_inst.frame(32'h00000c07, 12, rx);
    chk("short", 16'h0000, rx[15:0]);
    taps();
    end_of_test();
  end
endmodule
bind dwsr_top dwsr_top_properties dwsr_top_properties_inst (.sys_clk, .srst, .clk_en, .spi_sck,
  .spi_cs_n, .spi_sdo_o, .spi_sdo_oe, .wiper_tap_ch0, .wiper_tap_ch1, .power_down_n, .standby);
`default_nettype wire
